// ### hdl/flash_prog_regs.svh
// command codes, status bit positions, reset values and timing counts of the program sequencer
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

// command codes seen on the low data byte
`define FP_CMD_PROG_SETUP     8'h40
`define FP_CMD_PROG_SETUP_ALT 8'h10
`define FP_CMD_STREAM_SETUP   8'h30
`define FP_CMD_CONFIRM        8'hd0
`define FP_CMD_READ_ARRAY     8'hff
`define FP_CMD_READ_STATUS    8'h70
`define FP_CMD_CLEAR_STATUS   8'h50
`define FP_CMD_READ_ID        8'h90
`define FP_CMD_READ_QUERY     8'h98
`define FP_CMD_SUSPEND        8'hb0

// status bit positions
`define FP_SR_READY    7
`define FP_SR_PROG_ERR 4
`define FP_SR_VPP_ERR  3
`define FP_SR_SUSP     2
`define FP_SR_LOCK_ERR 1
`define FP_SR_PART     0

// reset values
`define FP_ERR_RESET   1'b0
`define FP_RDATA_RESET 16'h0000

// timing, times in ns, counts in cycles of the 20 ns clock
`define FP_CLK_NS         20
`define FP_PROG_NS        12000
`define FP_STREAM_SETUP_NS 5000
`define FP_PULSE_NS       3100
`define FP_PROG_CYC   ((`FP_PROG_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_SETUP_CYC  ((`FP_STREAM_SETUP_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_PULSE_CYC  ((`FP_PULSE_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)

`endif

// ### hdl/flash_prog_pkg.sv
// types shared by the program sequencer and its bench
package flash_prog_pkg;

	// one bus request as the host drives it
	typedef struct packed {
		logic [15:0] addr;  // word address
		logic [15:0] wdata; // command or data word
		logic        wr;    // write strobe
		logic        rd;    // read strobe
	} bus_req_t;

	// slow pins from outside the clock domain
	typedef struct packed {
		logic chip_en_n;  // chip enable, low active
		logic vpp_ok;     // program supply inside limits
		logic blk_locked; // addressed block is locked
		logic prog_fail;  // cell failed to verify
	} pins_t;

	// write state machine states
	typedef enum logic [2:0] {
		WSM_IDLE   = 3'b000,
		WSM_PROG   = 3'b001,
		WSM_SSETUP = 3'b010,
		WSM_SREADY = 3'b011,
		WSM_SPULSE = 3'b100
	} wsm_t;

	// pending first cycle of a two-write sequence
	typedef enum logic [1:0] {
		SEQ_NONE = 2'b00,
		SEQ_PROG = 2'b01,
		SEQ_STRM = 2'b10
	} seq_t;

	// per-partition read mode
	typedef enum logic [1:0] {
		MODE_ARRAY  = 2'b00,
		MODE_STATUS = 2'b01,
		MODE_ID     = 2'b10,
		MODE_QUERY  = 2'b11
	} mode_t;

endpackage : flash_prog_pkg

// ### hdl/flash_word_and_stream_program.sv
// word and streamed program sequencer of a multi-partition flash
`include "flash_prog_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_word_and_stream_program #(
	parameter int ADDR_W = 10,       // word address width of the array
	parameter int PART_W = 2,        // partition select bits at the top
	parameter int BLK_W  = 6,        // word bits inside one block
	parameter logic [15:0] ID_WORD    = 16'h00a5, // arbitrary identifier value
	parameter logic [15:0] QUERY_WORD = 16'h0051  // arbitrary query value
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire flash_prog_pkg::bus_req_t req,
	input  wire flash_prog_pkg::pins_t   pins,
	output logic [15:0]                  rdata_q,
	output logic                         standby_q
);

	localparam int PARTS = 1 << PART_W;
	localparam int WORDS = 1 << ADDR_W;

	////////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	logic       rst_meta_q;  // first reset stage
	logic       rst_sync_q;  // released reset, used everywhere but the cell array
	logic [3:0] pin_s1_q;    // first pin stage, read only by the second
	logic [3:0] pin_s2_q;    // second pin stage
	logic [3:0] pin_s3_q;    // third pin stage
	logic [3:0] pin_q;       // filtered pin levels
	logic       ce_off;      // chip enable released
	logic       vpp_good;    // supply in limits
	logic       locked;      // target block locked
	logic       fail;        // program failure seen

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// three flops per pin, change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_s1_q <= 4'h8;
			pin_s2_q <= 4'h8;
			pin_s3_q <= 4'h8;
			pin_q    <= 4'h8;
		end else begin
			pin_s1_q <= pins;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (int i = 0; i < 4; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i]) begin
					pin_q[i] <= pin_s3_q[i];
				end
			end
		end
	end

	assign ce_off   = pin_q[3];
	assign vpp_good = pin_q[2];
	assign locked   = pin_q[1];
	assign fail     = pin_q[0];

	////////////////////////////////////////////////////////////////////////////////
	// state

	flash_prog_pkg::wsm_t  wsm_q;                // write state machine
	flash_prog_pkg::seq_t  seq_q;                // pending setup write
	flash_prog_pkg::mode_t mode_q [PARTS];       // read mode per partition
	logic [15:0]           timer_q;              // internal operation timer
	logic [PART_W-1:0]     prog_part_q;          // partition being written
	logic [ADDR_W-1:0]     tgt_addr_q;           // target word address
	logic [15:0]           tgt_val_q;            // target word value
	logic [ADDR_W-1:0]     wa0_q;                // stream start address
	logic [ADDR_W-1:0]     next_q;               // stream next location
	logic                  susp_q;               // program suspended
	logic [PARTS-1:0]      ps_q;                 // program error per partition
	logic [PARTS-1:0]      vpps_q;               // supply error per partition
	logic [PARTS-1:0]      dps_q;                // lock error per partition
	logic [15:0]           mem [WORDS];          // cell array

	// partition field of an address
	function automatic logic [PART_W-1:0] part_of(input logic [15:0] a);
		part_of = a[ADDR_W-1 -: PART_W];
	endfunction : part_of

	// block field of an address
	function automatic logic [ADDR_W-BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
		blk_of = a[ADDR_W-1:BLK_W];
	endfunction : blk_of

	// status byte as seen from partition p
	function automatic logic [7:0] status_of(input logic [PART_W-1:0] p);
		logic       busy;
		logic [7:0] s;
		busy = (wsm_q != flash_prog_pkg::WSM_IDLE) && !susp_q;
		s = 8'h00;
		s[`FP_SR_READY]    = !busy;
		s[`FP_SR_PROG_ERR] = ps_q[p];
		s[`FP_SR_VPP_ERR]  = vpps_q[p];
		s[`FP_SR_LOCK_ERR] = dps_q[p];
		s[`FP_SR_SUSP]     = susp_q && (p == prog_part_q);
		if (wsm_q == flash_prog_pkg::WSM_SPULSE) begin
			s[`FP_SR_PART] = 1'b1;                                     // pulse running
		end else if (wsm_q == flash_prog_pkg::WSM_PROG && !susp_q) begin
			s[`FP_SR_PART] = (p != prog_part_q);
		end
		status_of = s;
	endfunction : status_of

	////////////////////////////////////////////////////////////////////////////////
	// request decode

	logic [PART_W-1:0] wpart;      // partition of the request
	logic [7:0]        cmd;        // command byte
	logic              streaming;  // stream mode active
	logic              prog_go;    // start word program
	logic              strm_go;    // start stream startup
	logic              word_go;    // start one stream pulse
	logic              strm_exit;  // leave stream mode
	logic              set_vpp;    // supply error now
	logic              set_lock;   // lock error now
	logic              clr_err;    // clear-status to wpart
	logic              resume;     // resume suspended program

	// classify each write
	always_comb begin
		wpart     = part_of(req.addr);
		cmd       = req.wdata[7:0];
		streaming = (wsm_q == flash_prog_pkg::WSM_SSETUP) ||
		            (wsm_q == flash_prog_pkg::WSM_SREADY) ||
		            (wsm_q == flash_prog_pkg::WSM_SPULSE);
		prog_go   = 1'b0;
		strm_go   = 1'b0;
		word_go   = 1'b0;
		strm_exit = 1'b0;
		set_vpp   = 1'b0;
		set_lock  = 1'b0;
		clr_err   = 1'b0;
		resume    = 1'b0;
		if (req.wr) begin
			if (streaming) begin
				// in stream ready a write inside the start block is stream data, commands included; one outside exits
				if (wsm_q == flash_prog_pkg::WSM_SREADY) begin
					if (blk_of(req.addr[ADDR_W-1:0]) != blk_of(wa0_q)) begin
						strm_exit = 1'b1;
					end else begin
						word_go = 1'b1;
					end
				end
			end else if (seq_q == flash_prog_pkg::SEQ_PROG) begin
				// second write of a word program carries the data
				if (vpps_q[wpart]) begin
					prog_go = 1'b0;
				end else if (!vpp_good) begin
					set_vpp = 1'b1;
				end else if (locked) begin
					set_lock = 1'b1;
				end else begin
					prog_go = 1'b1;
				end
			end else if (seq_q == flash_prog_pkg::SEQ_STRM) begin
				strm_go = (cmd == `FP_CMD_CONFIRM) && !vpps_q[wpart];
			end else begin
				clr_err = (cmd == `FP_CMD_CLEAR_STATUS) &&
				          (wsm_q == flash_prog_pkg::WSM_IDLE || wpart != prog_part_q);
				resume  = (cmd == `FP_CMD_CONFIRM) && susp_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// setup sequence and read modes

	// first write of a two-write sequence and per-partition read mode
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			seq_q <= flash_prog_pkg::SEQ_NONE;
			for (int i = 0; i < PARTS; i++) begin
				mode_q[i] <= flash_prog_pkg::MODE_ARRAY;
			end
		end else if (req.wr && !streaming) begin
			if (seq_q != flash_prog_pkg::SEQ_NONE) begin
				seq_q <= flash_prog_pkg::SEQ_NONE;
			end else if (wsm_q != flash_prog_pkg::WSM_IDLE && !susp_q &&
			             wpart == prog_part_q) begin
				// busy partition takes only a few commands
				unique case (cmd)
					`FP_CMD_READ_STATUS: mode_q[wpart] <= flash_prog_pkg::MODE_STATUS;
					`FP_CMD_READ_ID:     mode_q[wpart] <= flash_prog_pkg::MODE_ID;
					`FP_CMD_READ_QUERY:  mode_q[wpart] <= flash_prog_pkg::MODE_QUERY;
					`FP_CMD_READ_ARRAY:  mode_q[wpart] <= flash_prog_pkg::MODE_ARRAY;
					// a suspend shows its status straight away
					`FP_CMD_SUSPEND:     mode_q[wpart] <= flash_prog_pkg::MODE_STATUS;
					default:             mode_q[wpart] <= mode_q[wpart];
				endcase
			end else begin
				unique case (cmd)
					`FP_CMD_PROG_SETUP, `FP_CMD_PROG_SETUP_ALT: begin
						if (wsm_q == flash_prog_pkg::WSM_IDLE) begin   // one at a time
							seq_q <= flash_prog_pkg::SEQ_PROG;
						end
						mode_q[wpart] <= flash_prog_pkg::MODE_STATUS;
					end
					`FP_CMD_STREAM_SETUP: begin
						if (wsm_q == flash_prog_pkg::WSM_IDLE) begin
							seq_q <= flash_prog_pkg::SEQ_STRM;
						end
						mode_q[wpart] <= flash_prog_pkg::MODE_STATUS;
					end
					`FP_CMD_READ_ARRAY:  mode_q[wpart] <= flash_prog_pkg::MODE_ARRAY;
					`FP_CMD_READ_ID:     mode_q[wpart] <= flash_prog_pkg::MODE_ID;
					`FP_CMD_READ_QUERY:  mode_q[wpart] <= flash_prog_pkg::MODE_QUERY;
					default:             mode_q[wpart] <= flash_prog_pkg::MODE_STATUS;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write state machine

	// sequencing, timer and target capture
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wsm_q       <= flash_prog_pkg::WSM_IDLE;
			timer_q     <= 16'h0000;
			prog_part_q <= '0;
			tgt_addr_q  <= '0;
			tgt_val_q   <= 16'hffff;
			wa0_q       <= '0;
			next_q      <= '0;
			susp_q      <= 1'b0;
		end else begin
			unique case (wsm_q)
				flash_prog_pkg::WSM_IDLE: begin
					if (prog_go) begin
						wsm_q       <= flash_prog_pkg::WSM_PROG;
						timer_q     <= 16'(`FP_PROG_CYC);
						prog_part_q <= wpart;
						tgt_addr_q  <= req.addr[ADDR_W-1:0];
						tgt_val_q   <= req.wdata;
					end else if (strm_go) begin
						wsm_q       <= flash_prog_pkg::WSM_SSETUP;
						timer_q     <= 16'(`FP_SETUP_CYC);
						prog_part_q <= wpart;
						wa0_q       <= req.addr[ADDR_W-1:0];
						next_q      <= req.addr[ADDR_W-1:0];
					end
				end
				flash_prog_pkg::WSM_PROG: begin
					if (req.wr && !susp_q && wpart == prog_part_q &&
					    cmd == `FP_CMD_SUSPEND && seq_q == flash_prog_pkg::SEQ_NONE) begin
						susp_q <= 1'b1;
					end else if (resume) begin
						susp_q <= 1'b0;
					end else if (susp_q) begin
						timer_q <= timer_q;                               // halted
					end else if (timer_q == 16'h0000) begin
						wsm_q <= flash_prog_pkg::WSM_IDLE;
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				flash_prog_pkg::WSM_SSETUP: begin
					if (timer_q != 16'h0000) begin
						timer_q <= timer_q - 16'h0001;
					end else if (!vpp_good || locked) begin
						wsm_q <= flash_prog_pkg::WSM_IDLE;
					end else begin
						wsm_q <= flash_prog_pkg::WSM_SREADY;
					end
				end
				flash_prog_pkg::WSM_SREADY: begin
					if (strm_exit) begin
						wsm_q <= flash_prog_pkg::WSM_IDLE;
					end else if (word_go) begin
						wsm_q      <= flash_prog_pkg::WSM_SPULSE;
						timer_q    <= 16'(`FP_PULSE_CYC);
						tgt_val_q  <= req.wdata;
						// same address streams on, another one jumps
						tgt_addr_q <= (req.addr[ADDR_W-1:0] == wa0_q) ? next_q
						                                                : req.addr[ADDR_W-1:0];
					end
				end
				flash_prog_pkg::WSM_SPULSE: begin
					if (timer_q != 16'h0000) begin
						timer_q <= timer_q - 16'h0001;
					end else begin
						wsm_q  <= flash_prog_pkg::WSM_SREADY;
						next_q <= ADDR_W'(tgt_addr_q + 1'b1);
					end
				end
				default: wsm_q <= flash_prog_pkg::WSM_IDLE;
			endcase
		end
	end

	logic pulse_end;  // last cycle of a program pulse
	assign pulse_end = (timer_q == 16'h0000) &&
	                   ((wsm_q == flash_prog_pkg::WSM_PROG && !susp_q && !resume &&
	                     !(req.wr && wpart == prog_part_q && cmd == `FP_CMD_SUSPEND)) ||
	                    wsm_q == flash_prog_pkg::WSM_SPULSE);

	// cell array: ones leave a cell alone, zeros clear it
	always_ff @(posedge clk) begin
		if (pulse_end && !fail) begin
			mem[tgt_addr_q] <= mem[tgt_addr_q] & tgt_val_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// error bits, set wins over clear

	// sticky error bits per partition
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ps_q   <= {PARTS{`FP_ERR_RESET}};
			vpps_q <= {PARTS{`FP_ERR_RESET}};
			dps_q  <= {PARTS{`FP_ERR_RESET}};
		end else begin
			if (clr_err) begin
				ps_q[wpart]   <= 1'b0;
				vpps_q[wpart] <= 1'b0;
				dps_q[wpart]  <= 1'b0;
			end
			if (set_vpp) begin
				vpps_q[wpart] <= 1'b1;
			end
			if (set_lock) begin
				dps_q[wpart] <= 1'b1;
			end
			if (pulse_end && fail) begin
				ps_q[prog_part_q] <= 1'b1;
			end
			if (wsm_q == flash_prog_pkg::WSM_SSETUP && timer_q == 16'h0000) begin
				if (!vpp_good) begin
					vpps_q[prog_part_q] <= 1'b1;
				end
				if (locked) begin
					dps_q[prog_part_q] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path and standby

	// read data one cycle after the strobe; status sampled fresh each poll
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rdata_q <= `FP_RDATA_RESET;
		end else if (!req.rd) begin
			rdata_q <= 16'h0000;
		end else if (streaming || mode_q[part_of(req.addr)] == flash_prog_pkg::MODE_STATUS) begin
			rdata_q <= {8'h00, status_of(part_of(req.addr))};
		end else begin
			unique case (mode_q[part_of(req.addr)])
				flash_prog_pkg::MODE_ID:    rdata_q <= ID_WORD;
				flash_prog_pkg::MODE_QUERY: rdata_q <= QUERY_WORD;
				default:                    rdata_q <= mem[req.addr[ADDR_W-1:0]];
			endcase
		end
	end

	// standby only once chip enable is off and nothing runs
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			standby_q <= 1'b0;
		end else begin
			standby_q <= ce_off && (wsm_q == flash_prog_pkg::WSM_IDLE || susp_q);
		end
	end

endmodule : flash_word_and_stream_program

`default_nettype wire

// ### dv/flash_prog_monitor.sv
// assertion checker of the word and streamed program sequencer ports
`timescale 1ns/1ps
`default_nettype none
module flash_prog_monitor #(
	parameter int ADDR_W = 10, // word address width
	parameter int PART_W = 2   // partition select bits
) (
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire flash_prog_pkg::bus_req_t req,
	input wire flash_prog_pkg::pins_t    pins,
	input wire logic [15:0]              rdata_q,
	input wire logic                     standby_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	logic [15:0]       cnt_q; // cycles left of a healthy word program
	logic [15:0]       a_q;   // address of the last write
	logic [PART_W-1:0] p_q;   // partition being programmed
	logic              su_q;  // program setup waits for its data
	logic              vpp_q; // supply error may still be set
	logic              ok_q;  // busy partition still in status mode
	wire               dw = req.wr && su_q && req.addr == a_q; // data write
	// shadow of the word program, errors and read mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
			a_q   <= 16'h0000;
			p_q   <= '0;
			su_q  <= 1'b0;
			vpp_q <= 1'b0;
			ok_q  <= 1'b0;
		end else begin
			if (req.wr) a_q <= req.addr;
			if (req.wr) su_q <= !su_q && (req.wdata[7:0] == 8'h40 || req.wdata[7:0] == 8'h10);
			if (dw && pins.vpp_ok && !pins.blk_locked && !vpp_q) begin
				cnt_q <= 16'd590;
				p_q   <= req.addr[ADDR_W-1 -: PART_W];
			end else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
			if (dw && !pins.vpp_ok) vpp_q <= 1'b1;
			else if (req.wr && req.wdata[7:0] == 8'h50) vpp_q <= 1'b0;
			if (dw) ok_q <= 1'b1;
			else if (req.wr) ok_q <= req.wdata[7:0] == 8'h70;
		end
	end
	////////////////////////////////////////
	sequence s_stat;
		req.wr && req.wdata[7:0] == 8'h70 ##2 req.rd && req.addr == $past(req.addr, 2);
	endsequence
	sequence s_strm;
		req.wr && req.wdata[7:0] == 8'h30 ##2 req.wr && req.wdata[7:0] == 8'hd0;
	endsequence
	sequence s_bad;
		req.wr && req.wdata[7:0] == 8'h40 ##2 req.wr && !pins.vpp_ok;
	endsequence
	AST_RD_IDLE: assert property (!$past(req.rd) |-> rdata_q == 16'h0000)
		else $error("read data outside its cycle");
	AST_STAT_HIGH: assert property (s_stat |=> rdata_q[15:8] == 8'h00 && rdata_q[6:5] == 2'b00)
		else $error("status upper byte not zero");
	AST_STRM_BUSY: assert property (s_strm ##[1:200] req.rd |=> !rdata_q[7])
		else $error("ready bit high during stream startup");
	AST_WORD_BUSY: assert property (cnt_q > 16'd2 && ok_q && req.rd && req.addr[ADDR_W-1 -: PART_W] == p_q |=> rdata_q[7:0] == 8'h00)
		else $error("busy partition status wrong");
	AST_WORD_OTHER: assert property (cnt_q > 16'd4 && req.wr && req.wdata[7:0] == 8'h70 && req.addr[ADDR_W-1 -: PART_W] != p_q ##2 req.rd && req.addr == $past(req.addr, 2) |=> rdata_q[7:0] == 8'h01)
		else $error("other partition status wrong");
	AST_STBY_BUSY: assert property (cnt_q > 16'd8 && cnt_q < 16'd588 |-> !standby_q)
		else $error("standby during program");
	AST_STBY_EN: assert property ((!pins.chip_en_n) [*8] |-> !standby_q)
		else $error("standby while chip enabled");
	AST_VPP_ERR: assert property (s_bad ##2 req.rd && req.addr == $past(req.addr, 2) |=> rdata_q[7] && rdata_q[3])
		else $error("supply error not reported");
endmodule : flash_prog_monitor
bind flash_word_and_stream_program flash_prog_monitor #(.ADDR_W(ADDR_W), .PART_W(PART_W)) mon (.clk(clk), .rst_n(rst_n), .req(req), .pins(pins), .rdata_q(rdata_q), .standby_q(standby_q));
`default_nettype wire

// ### dv/flash_host_model.sv
// host model: drives the command port and the slow pins
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
	input  wire logic                    clk,
	input  wire logic [15:0]             rdata_q,
	output var flash_prog_pkg::bus_req_t req,
	output var flash_prog_pkg::pins_t    pins
);
	// idle bus, chip enabled, healthy supply from time zero
	initial begin
		req  = '0;
		pins = 4'b0100;
	end
	// one write cycle, then the lines turn over
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '{~a, ~d, 1'b0, 1'b0};
	endtask : wr
	// each read is one enable toggle, data stands one cycle
	task rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		req <= '{~a, 16'hffff, 1'b0, 1'b0};
		#1 d = rdata_q;
	endtask : rd
	// pins change, then settle through the input filter
	task pin(input flash_prog_pkg::pins_t p);
		@(posedge clk);
		pins <= p;
		repeat (6) @(posedge clk);
	endtask : pin
endmodule : flash_host_model
`default_nettype wire

// ### dv/tb_flash_word_and_stream_program.sv
// self-checking bench of the word and streamed program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"
module tb_flash_word_and_stream_program;
	localparam logic [15:0] A0 = 16'h0010; // word in partition 0
	localparam logic [15:0] A1 = 16'h0110; // word in partition 1
	localparam logic [15:0] S0 = 16'h0220; // stream start in partition 2
	logic                     clk;       // 50 MHz clock
	logic                     rst_n;     // reset, low active
	flash_prog_pkg::bus_req_t req;       // host request
	flash_prog_pkg::pins_t    pins;      // slow pins
	logic [15:0]              rdata_q;   // read data
	logic                     standby_q; // standby level
	logic [15:0]              rv;        // last value read
	int                       failures;  // mismatches seen
	int                       checked;   // comparisons made
	////////////////////////////////////////
	flash_word_and_stream_program dut (.clk(clk), .rst_n(rst_n), .req(req), .pins(pins), .rdata_q(rdata_q), .standby_q(standby_q));
	flash_host_model host (.clk(clk), .rdata_q(rdata_q), .req(req), .pins(pins));
	// free running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////
	task give_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// read a partition already in status mode
	task st(input logic [15:0] a, input logic [7:0] e, input string n);
		host.rd(a, rv);
		chk(n, {8'h00, e}, rv);
	endtask : st
	// poll one status bit under a bound
	task wait_bit(input logic [15:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			host.rd(a, rv);
			n++;
		end while (rv[b] !== v && n < 3000);
		if (n >= 3000) begin
			failures++;
			give_verdict;
		end
	endtask : wait_bit
	task prog(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
		host.wr(a, {8'h00, c});
		host.wr(a, d);
	endtask : prog
	////////////////////////////////////////
	task t_word;
		host.wr(A0, 16'h0070);
		st(A0, 8'h80, "reset status");
		prog(8'h40, A0, 16'hff00);
		st(A0, 8'h00, "busy own");
		host.wr(A1, 16'h0070);
		st(A1, 8'h01, "busy other");
		wait_bit(A0, 7, 1'b1);
		st(A0, 8'h80, "done");
		prog(8'h10, A0, 16'h00ff);
		wait_bit(A0, 7, 1'b1);
		prog(8'h40, A0, 16'hffff);
		wait_bit(A0, 7, 1'b1);
		host.wr(A0, 16'h00ff);
		host.rd(A0, rv);
		chk("array word", 16'h0000, rv);
		$display("test word done");
	endtask : t_word
	task t_busy;
		prog(8'h40, A1, 16'h0000);
		host.wr(A1, 16'h0090);
		host.rd(A1, rv);
		chk("identifier", 16'h00a5, rv);
		host.wr(A1, 16'h0098);
		host.rd(A1, rv);
		chk("query", 16'h0051, rv);
		host.wr(A1, 16'h00b0);
		st(A1, 8'h84, "suspended");
		host.wr(A1, 16'h00d0);
		host.wr(A1, 16'h0070);
		st(A1, 8'h00, "resumed");
		wait_bit(A1, 7, 1'b1);
		prog(8'h40, A0, 16'h0000);
		host.pin(4'b1100);
		chk("standby busy", 16'h0000, {15'h0000, standby_q});
		repeat (`FP_PROG_CYC + 10) @(posedge clk);
		chk("standby idle", 16'h0001, {15'h0000, standby_q});
		host.pin(4'b0100);
		$display("test busy done");
	endtask : t_busy
	task t_err;
		host.pin(4'b0000);
		prog(8'h40, A0, 16'h0000);
		st(A0, 8'h88, "supply error");
		host.pin(4'b0100);
		prog(8'h40, A0, 16'h0000);
		st(A0, 8'h88, "refused");
		host.wr(A0, 16'h0050);
		st(A0, 8'h80, "cleared");
		host.pin(4'b0110);
		prog(8'h40, A0, 16'h0000);
		st(A0, 8'h82, "lock error");
		host.wr(A0, 16'h0050);
		host.pin(4'b0101);
		prog(8'h40, A0, 16'h0000);
		wait_bit(A0, 7, 1'b1);
		st(A0, 8'h90, "program error");
		host.wr(A0, 16'h0050);
		host.pin(4'b0100);
		$display("test errors done");
	endtask : t_err
	task t_strm;
		host.wr(S0, 16'h0030);
		host.wr(S0, 16'h00d0);
		host.rd(A0, rv);
		chk("stream startup", 16'h0000, rv & 16'hff80);
		repeat (`FP_SETUP_CYC + 10) @(posedge clk);
		st(S0, 8'h00, "stream ready");
		host.wr(S0, 16'h0000);
		st(S0, 8'h01, "pulse");
		wait_bit(S0, 0, 1'b0);
		host.wr(S0, 16'h0000);
		wait_bit(S0, 0, 1'b0);
		host.wr(S0 + 16'h0040, 16'hffff);
		host.wr(S0, 16'h0070);
		st(S0, 8'h80, "stream exit");
		host.wr(S0, 16'h00ff);
		host.rd(S0, rv);
		chk("first word", 16'h0000, rv);
		host.rd(S0 + 16'h0001, rv);
		chk("next word", 16'h0000, rv);
		host.pin(4'b0110);
		host.wr(S0, 16'h0030);
		host.wr(S0, 16'h00d0);
		repeat (`FP_SETUP_CYC + 10) @(posedge clk);
		host.wr(S0, 16'h0070);
		st(S0, 8'h82, "stream lock");
		host.wr(S0, 16'h0050);
		host.pin(4'b0100);
		$display("test stream done");
	endtask : t_strm
	////////////////////////////////////////
	// reset, then the scenarios in turn
	initial begin
		failures = 0;
		checked  = 0;
		rst_n    = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_word;
		t_busy;
		t_err;
		t_strm;
		give_verdict;
	end
endmodule : tb_flash_word_and_stream_program
`default_nettype wire
